// ### pkg/asd_pkg.sv
// Package: register map, fields and reset values of the scan DMA control
`default_nettype none
package asd_pkg;
  // Printed offsets are not multiples of four: kept as word indices
  localparam logic [11:0] IDX_SCAN_CONTROL  = 12'hFBE;
  localparam logic [11:0] IDX_RESULT_BASE   = 12'hFBD;
  localparam logic [11:0] IDX_STATUS        = 12'hFBF;
  localparam logic [11:0] IDX_IRQ_STATUS    = 12'hFC0;
  localparam logic [11:0] IDX_IRQ_MASK      = 12'hFC1;
  localparam int          ADDR_W            = 16;
  localparam int          BIT_SCAN_EN       = 7;
  localparam int          BIT_SCAN_IRQ_EN   = 6;
  localparam int          LAST_LSB          = 0;
  localparam int          CUR_LSB           = 4;
  localparam int          BIT_SCAN_DONE     = 2;
  localparam int          BIT_CH1_DONE      = 1;
  localparam int          BIT_CH0_DONE      = 0;
  localparam logic [3:0]  LAST_MAX          = 4'hB;
  localparam logic [7:0]  RST_SCAN_CONTROL  = 8'h00;
  localparam logic [7:0]  RST_STATUS        = 8'h00;
  localparam logic [6:0]  RST_RESULT_BASE   = 7'h00;
  localparam logic [2:0]  RST_IRQ_MASK      = 3'h0;
  localparam logic [3:0]  RST_INPUT         = 4'h0;
  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_CONV_REQ,
    ST_CONV_WAIT,
    ST_WR_HI,
    ST_WR_LO
  } asd_state_t;
endpackage
`default_nettype wire

// ### verilog/asd_flags.sv
// Sticky completion flags, cleared by a status read, set wins over clear
`default_nettype none
module asd_flags #(
  parameter int N = 3
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [N-1:0] set_evt,
  input  wire logic         clear,
  output var  logic [N-1:0] flags
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags <= '0;
    else
      flags <= set_evt | (clear ? '0 : flags);
  end

  a_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (clear && set_evt == '0) |=> flags == '0) else $error("flags not cleared");
  a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (set_evt != '0) |=> ((flags & $past(set_evt)) == $past(set_evt)))
    else $error("event lost");
endmodule
`default_nettype wire

// ### verilog/asd_scan_dma.sv
// ADC scan DMA control and status block with APB register slave
`default_nettype none
module asd_scan_dma
  import asd_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  output var  logic              conv_start,
  output var  logic [3:0]        conv_input,
  input  wire logic              conv_done,
  input  wire logic [9:0]        conv_result,
  output var  logic              mem_we,
  output var  logic [11:0]       mem_addr,
  output var  logic [7:0]        mem_wdata,
  input  wire logic              mem_ack,
  input  wire logic              ch0_end_irq,
  input  wire logic              ch1_end_irq,
  output var  logic              scan_irq,
  output var  logic              irq
);
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [6:0]  base;
    logic [2:0]  mask;
    logic [2:0]  irq_sticky;
    asd_state_t  st;
    logic [3:0]  cur;
    logic [9:0]  result;
    logic        conv_start;
    logic        mem_we;
    logic [11:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic        scan_irq;
    logic        irq;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } asd_regs_t;

  asd_regs_t   r;
  asd_regs_t   next_r;
  logic [2:0]  flags;
  logic [2:0]  done_evt;
  logic        stat_read;
  logic        acc;
  logic [11:0] idx;
  logic        hit;

  function automatic logic [11:0] word_index(input logic [ADDR_W-1:0] a);
    word_index = a[13:2];
  endfunction

  function automatic logic [11:0] result_addr(input logic [6:0] b,
                                              input logic [3:0] n,
                                              input logic       odd);
    result_addr = {b, n, odd};
  endfunction

  assign acc       = psel && penable && !r.pready;
  assign idx       = word_index(paddr);
  assign hit       = (idx == IDX_SCAN_CONTROL) || (idx == IDX_RESULT_BASE) ||
                     (idx == IDX_STATUS) || (idx == IDX_IRQ_STATUS) ||
                     (idx == IDX_IRQ_MASK);
  assign stat_read = acc && !pwrite && (idx == IDX_STATUS);

  asd_flags #(
    .N (3)
  ) u_flags (
    .pclk    (pclk),
    .presetn (presetn),
    .set_evt (done_evt),
    .clear   (stat_read),
    .flags   (flags)
  );

  always_comb
  begin
    next_r            = r;
    next_r.pready     = 1'b0;
    next_r.pslverr    = 1'b0;
    next_r.conv_start = 1'b0;
    next_r.scan_irq   = 1'b0;
    done_evt          = 3'h0;
    done_evt[BIT_CH1_DONE] = ch1_end_irq;
    done_evt[BIT_CH0_DONE] = ch0_end_irq;

    if (acc)
    begin
      next_r.pready  = 1'b1;
      next_r.pslverr = !hit;
      next_r.prdata  = 32'h0000_0000;
      if (pwrite && pstrb[0])
      begin
        case (idx)
          IDX_SCAN_CONTROL: next_r.ctrl = pwdata[7:0] & 8'hCF;
          IDX_RESULT_BASE:  next_r.base = pwdata[7:1];
          IDX_IRQ_MASK:     next_r.mask = pwdata[2:0];
          IDX_IRQ_STATUS:   next_r.irq_sticky = r.irq_sticky & ~pwdata[2:0];
          default:          next_r.base = r.base;
        endcase
      end
      else if (!pwrite)
      begin
        case (idx)
          IDX_SCAN_CONTROL: next_r.prdata = {24'h0, r.ctrl};
          IDX_RESULT_BASE:  next_r.prdata = {24'h0, r.base, 1'b0};
          IDX_STATUS:       next_r.prdata = {24'h0, r.cur, 1'b0, flags};
          IDX_IRQ_STATUS:   next_r.prdata = {29'h0, r.irq_sticky};
          IDX_IRQ_MASK:     next_r.prdata = {29'h0, r.mask};
          default:          next_r.prdata = 32'h0000_0000;
        endcase
      end
    end

    case (r.st)
      ST_IDLE:
      begin
        next_r.cur = RST_INPUT;
        if (r.ctrl[BIT_SCAN_EN])
          next_r.st = ST_CONV_REQ;
      end
      ST_CONV_REQ:
      begin
        next_r.conv_start = 1'b1;
        next_r.st         = ST_CONV_WAIT;
      end
      ST_CONV_WAIT:
      begin
        if (conv_done)
        begin
          next_r.result    = conv_result;
          next_r.mem_we    = 1'b1;
          next_r.mem_addr  = result_addr(r.base, r.cur, 1'b0);
          next_r.mem_wdata = conv_result[9:2];
          next_r.st        = ST_WR_HI;
        end
      end
      ST_WR_HI:
      begin
        if (mem_ack)
        begin
          next_r.mem_addr  = result_addr(r.base, r.cur, 1'b1);
          next_r.mem_wdata = {r.result[1:0], 6'h00};
          next_r.st        = ST_WR_LO;
        end
      end
      ST_WR_LO:
      begin
        if (mem_ack)
        begin
          next_r.mem_we = 1'b0;
          next_r.st     = ST_CONV_REQ;
          if (r.cur >= r.ctrl[LAST_LSB +: 4] || r.cur >= LAST_MAX)
          begin
            next_r.cur = RST_INPUT;
            if (r.ctrl[BIT_SCAN_IRQ_EN])
              next_r.scan_irq = 1'b1;
          end
          else
            next_r.cur = r.cur + 4'h1;
        end
      end
      default: next_r.st = ST_IDLE;
    endcase

    if (!r.ctrl[BIT_SCAN_EN])
    begin
      next_r.st     = ST_IDLE;
      next_r.cur    = RST_INPUT;
      next_r.mem_we = 1'b0;
    end

    done_evt[BIT_SCAN_DONE] = r.scan_irq;
    next_r.irq_sticky = next_r.irq_sticky | done_evt;
    next_r.irq        = |(next_r.irq_sticky & r.mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r      <= '0;
      r.ctrl <= RST_SCAN_CONTROL;
      r.base <= RST_RESULT_BASE;
      r.mask <= RST_IRQ_MASK;
      r.cur  <= RST_INPUT;
      r.st   <= ST_IDLE;
    end
    else
      r <= next_r;
  end

  assign prdata     = r.prdata;
  assign pready     = r.pready;
  assign pslverr    = r.pslverr;
  assign conv_start = r.conv_start;
  assign conv_input = r.cur;
  assign mem_we     = r.mem_we;
  assign mem_addr   = r.mem_addr;
  assign mem_wdata  = r.mem_wdata;
  assign scan_irq   = r.scan_irq;
  assign irq        = r.irq;

  a_disable_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !r.ctrl[BIT_SCAN_EN] |=> conv_input == 4'h0) else $error("input not 0");
  a_irq_off: assert property (@(posedge pclk) disable iff (!presetn)
    !r.ctrl[BIT_SCAN_IRQ_EN] |=> !scan_irq) else $error("irq while off");
  a_irq_last: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == ST_WR_LO && mem_ack && r.ctrl[BIT_SCAN_EN] &&
     r.ctrl[BIT_SCAN_IRQ_EN] && r.cur == r.ctrl[3:0]) |=> scan_irq)
    else $error("missing scan irq");
  a_ascend: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(r.cur) |-> (r.cur == 4'h0 || r.cur == $past(r.cur) + 4'h1))
    else $error("input order");
  a_conv_first: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(mem_we) |-> $past(conv_done)) else $error("write before conv");
  a_addr_form: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == ST_WR_HI) |-> mem_addr == {r.base, r.cur, 1'b0})
    else $error("bad address");
  a_done_set: assert property (@(posedge pclk) disable iff (!presetn)
    scan_irq |=> flags[BIT_SCAN_DONE]) else $error("scan done not set");
  a_stat_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (stat_read && !scan_irq && !ch0_end_irq && !ch1_end_irq) |=> flags == 3'h0)
    else $error("status read no clear");
  a_reserved_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    r.ctrl[5:4] == 2'b00) else $error("reserved control bits set");
  a_cur_limit: assert property (
    @(posedge pclk) disable iff (!presetn)
    conv_input <= LAST_MAX) else $error("input number above limit");
  a_idle_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (r.st == ST_IDLE) |=> conv_input == 4'h0) else $error("idle not at 0");
  a_start_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    conv_start |=> !conv_start) else $error("start longer than a cycle");
  a_we_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mem_we && !mem_ack && r.ctrl[BIT_SCAN_EN]) |=> mem_we)
    else $error("write dropped early");
  a_cur_status: assert property (
    @(posedge pclk) disable iff (!presetn)
    stat_read |=> prdata[7:4] == $past(conv_input))
    else $error("status input field wrong");
  a_ch1_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    ch1_end_irq |=> flags[BIT_CH1_DONE]) else $error("channel 1 flag lost");
  a_ch0_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    ch0_end_irq |=> flags[BIT_CH0_DONE]) else $error("channel 0 flag lost");
  a_hi_byte: assert property (
    @(posedge pclk) disable iff (!presetn)
    (r.st == ST_WR_HI) |-> mem_wdata == r.result[9:2])
    else $error("bad high byte");
  a_lo_byte: assert property (
    @(posedge pclk) disable iff (!presetn)
    (r.st == ST_WR_LO) |-> mem_wdata == {r.result[1:0], 6'h00})
    else $error("bad low byte");
  a_odd_addr: assert property (
    @(posedge pclk) disable iff (!presetn)
    (r.st == ST_WR_LO) |-> mem_addr == {r.base, r.cur, 1'b1})
    else $error("bad odd address");
  a_wrap_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (r.st == ST_WR_LO && mem_ack && r.ctrl[BIT_SCAN_EN] &&
     r.cur == r.ctrl[3:0]) |=> conv_input == 4'h0) else $error("no wrap");
  a_flag_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    (flags[BIT_SCAN_DONE] && !stat_read) |=> flags[BIT_SCAN_DONE])
    else $error("scan done flag lost");
  a_scan_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    scan_irq |=> !scan_irq) else $error("scan irq longer than a cycle");
  a_irq_source: assert property (
    @(posedge pclk) disable iff (!presetn)
    scan_irq |-> $past(r.st) == ST_WR_LO) else $error("scan irq misplaced");
  // Error only with ready
  a_err_ready: assert property (
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> pready) else $error("error without ready");
  // Ready lasts one cycle
  a_ready_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("ready longer than a cycle");
endmodule
`default_nettype wire

// ### verification/asd_adc_mem_model.sv
// Converter and result memory model facing the scan DMA
`default_nettype none
module asd_adc_mem_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        conv_start,
  input  wire logic [3:0]  conv_input,
  output var  logic        conv_done,
  output var  logic [9:0]  conv_result,
  input  wire logic        mem_we,
  input  wire logic [11:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output var  logic        mem_ack,
  input  wire logic [1:0]  slow
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [4096];
  logic [3:0] cc;
  logic [1:0] wc;
  logic [9:0] res;
  logic       take;
  assign res = {conv_input, 6'h15};
  // Result valid only with the done pulse
  assign conv_result = conv_done ? res : ~res;
  assign take = mem_we && !mem_ack;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cc <= 4'h0;
      wc <= 2'h0;
      conv_done <= 1'b0;
      mem_ack <= 1'b0;
    end
    else
    begin
      conv_done <= cc == 4'h1;
      cc <= conv_start ? 4'h3 + 4'(slow) : (cc != 4'h0 ? cc - 4'h1 : 4'h0);
      mem_ack <= take && wc == slow;
      wc <= (take && wc != slow) ? wc + 2'h1 : 2'h0;
      if (mem_we && mem_ack)
        mem[mem_addr] <= mem_wdata;
    end
endmodule
`default_nettype wire

// ### verification/asd_scan_dma_tb.sv
// Self-checking bench of the scan DMA control block
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  num_errors++; $display("Error %0t: got %h exp %h", $time, a, b); end end
module asd_scan_dma_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import asd_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, conv_input;
  logic conv_start, conv_done, mem_we, mem_ack, er;
  logic ch0_end_irq, ch1_end_irq, scan_irq, irq;
  logic [9:0]  conv_result;
  logic [11:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic [1:0]  slow;
  logic [3:0]  starts [$];
  int num_errors, samples_checked, irqs;
  asd_scan_dma i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_start(conv_start), .conv_input(conv_input),
    .conv_done(conv_done), .conv_result(conv_result), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .ch0_end_irq(ch0_end_irq), .ch1_end_irq(ch1_end_irq),
    .scan_irq(scan_irq), .irq(irq));
  asd_adc_mem_model i_mdl (.pclk(pclk), .presetn(presetn),
    .conv_start(conv_start), .conv_input(conv_input),
    .conv_done(conv_done), .conv_result(conv_result), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .slow(slow));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    if (conv_start === 1'b1)
      starts.push_back(conv_input);
    if (scan_irq === 1'b1)
      irqs++;
  end
  task automatic stop_test;
    $display("Checks %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] i,
                     input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer; only the watchdog ends a hang
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    `CHK(rd, {24'h0, e})
  endtask
  task automatic t_reset;
    rd_chk(IDX_SCAN_CONTROL, RST_SCAN_CONTROL);
    rd_chk(IDX_STATUS, RST_STATUS);
    rd_chk(IDX_IRQ_MASK, 8'h00);
    // Write without byte strobe is ignored
    pstrb <= 4'h0;
    apb(1'b1, IDX_IRQ_MASK, 8'h07);
    pstrb <= 4'hF;
    rd_chk(IDX_IRQ_MASK, 8'h00);
    apb(1'b0, 12'h010, 8'h00);
    `CHK(er, 1'b1)
    `CHK(rd, 32'h0)
    $display("reset test done");
  endtask
  task automatic t_scan(input logic [3:0] last, input logic ie,
                        input logic [1:0] s, input logic [6:0] b);
    slow <= s;
    starts.delete();
    irqs = 0;
    apb(1'b1, IDX_RESULT_BASE, {b, 1'b0});
    apb(1'b1, IDX_SCAN_CONTROL, {1'b1, ie, 2'b00, last});
    while (starts.size() <= last + 1)
      @(posedge pclk);
    apb(1'b1, IDX_SCAN_CONTROL, 8'h00);
    @(posedge pclk);
    `CHK(conv_input, 4'h0)
    `CHK(irqs > 0, ie)
    for (int i = 0; i <= last + 1; i++)
      `CHK(starts[i], 4'(i % (last + 1)))
    for (int i = 0; i <= last; i++)
    begin
      `CHK(i_mdl.mem[{b, 4'(i), 1'b0}], {4'(i), 4'h5})
      `CHK(i_mdl.mem[{b, 4'(i), 1'b1}], 8'h40)
    end
    rd_chk(IDX_STATUS, {5'h0, ie, 2'b00});
    rd_chk(IDX_STATUS, 8'h00);
    $display("scan test done");
  endtask
  task automatic pulse(input logic c);
    @(posedge pclk);
    ch0_end_irq <= !c;
    ch1_end_irq <= c;
    @(posedge pclk);
    ch0_end_irq <= 1'b0;
    ch1_end_irq <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic t_evt;
    apb(1'b1, IDX_IRQ_STATUS, 8'h07);
    apb(1'b1, IDX_IRQ_MASK, 8'h01);
    pulse(1'b1);
    `CHK(irq, 1'b0)
    pulse(1'b0);
    `CHK(irq, 1'b1)
    rd_chk(IDX_STATUS, 8'h03);
    rd_chk(IDX_STATUS, 8'h00);
    rd_chk(IDX_IRQ_STATUS, 8'h03);
    apb(1'b1, IDX_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    rd_chk(IDX_IRQ_STATUS, 8'h02);
    $display("event test done");
  endtask
  initial
  begin
    {psel, penable, pwrite, ch0_end_irq, ch1_end_irq} = 5'h00;
    paddr = 16'h0000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    slow = 2'h0;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_scan(4'h2, 1'b1, 2'h0, 7'h72);
    t_scan(LAST_MAX, 1'b0, 2'h3, 7'h35);
    t_evt;
    stop_test;
  end
  initial
  begin
    // Whole run needs well under 2000 cycles
    #100us;
    num_errors++;
    stop_test;
  end
endmodule
`default_nettype wire
